// ==== bench/dcs_mem_model.sv ====
// Memory model that answers the channel's read and write ports
module dcs_mem_model
   import dcs_pkg::*;
(
   // Clock
   input  wire logic       aclk,
   // Channel requests
   input  wire logic       rd_req,
   input  wire dcs_xfer_s  rd_xfer,
   input  wire logic       wr_req,
   // Bench control: faults and wait length
   input  wire logic       fail_rd,
   input  wire logic       fail_wr,
   input  wire logic [1:0] lat,
   // Answers
   output logic            rd_done,
   output logic            rd_error,
   output logic [31:0]     rd_data = 32'h0,
   output logic            wr_done,
   output logic            wr_error
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] rc = 2'h0;  // Read wait count
   logic [1:0] wc = 2'h0;  // Write wait count
   // Answer after a varying wait; data outside a pending request toggles so stale words never look valid
   always_ff @(posedge aclk) begin
      rd_done <= 1'b0;
      wr_done <= 1'b0;
      rd_error <= 1'b0;
      wr_error <= 1'b0;
      rd_data <= ~rd_data;
      if (rd_req && !rd_done) begin
         rc <= (rc >= lat) ? 2'h0 : rc + 2'h1;
         rd_done <= rc >= lat;
         rd_error <= (rc >= lat) && fail_rd;
         rd_data <= {4{rd_xfer.addr[7:0]}} ^ 32'h11223344;
      end
      if (wr_req && !wr_done) begin
         wc <= (wc >= lat) ? 2'h0 : wc + 2'h1;
         wr_done <= wc >= lat;
         wr_error <= (wc >= lat) && fail_wr;
      end
   end
endmodule

// ==== bench/dma_channel_control_status_tb_top.sv ====
// Random and corner-case bench for the channel control block
`include "dcs_regs.svh"
module dma_channel_control_status_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import dcs_pkg::*;
   logic aclk = 0, aresetn = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, frd = 0, fwr = 0;
   logic rs = 1, bs = 1, sne = 1, pq = 0, rq_d = 0;
   logic [5:0]  ps = 6'h3f;
   logic [11:0] awa = 0, ara = 0;
   logic [31:0] wd = 0, d, c, ra, wa, exp_wr, exp_rd, nx, last_rd;
   logic [1:0]  rsp, lat = 0, sz;
   logic [3:0]  rn;
   logic [58:0] pdr = 0;
   logic [3:0]  tmr = 0;
   logic awr, wrd, bv, arr, rv, rdq, rdn, rde, wrq, wdn, wre, sv, irq, cf;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata, rdd, svd;
   logic [3:0]  ct;
   dcs_xfer_s   rx, wx;
   int mismatches = 0, check_count = 0, seed = 47, irq_n = 0, cf_n = 0, sv_n = 0, i0, c0, s0, i;
   dcs_channel dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd),
      .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
      .peripheral_data_request(pdr), .pace_timer(tmr), .chain_trigger_in(1'b0), .rd_req(rdq),
      .rd_xfer(rx), .rd_done(rdn), .rd_error(rde), .rd_data(rdd), .wr_req(wrq), .wr_xfer(wx),
      .wr_done(wdn), .wr_error(wre), .sniff_unit_enable(sne), .sniff_unit_channel(4'ha),
      .sniff_valid(sv), .sniff_data(svd), .channel_irq(irq), .chain_fire(cf), .chain_target(ct));
   dcs_mem_model mem_u (.aclk(aclk), .rd_req(rdq), .rd_xfer(rx), .wr_req(wrq), .fail_rd(frd),
      .fail_wr(fwr), .lat(lat), .rd_done(rdn), .rd_error(rde), .rd_data(rdd), .wr_done(wdn),
      .wr_error(wre));
   // Clock at 50 MHz
   initial forever #10 aclk = ~aclk;
   task results;
      if (mismatches == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask
   // Expected byte order of a transfer of the given width
   function automatic logic [31:0] rev(input logic [31:0] x, input logic [1:0] s);
      return s == 0 ? x : s == 1 ? {x[23:16], x[31:24], x[7:0], x[15:8]} : {x[7:0], x[15:8], x[23:16], x[31:24]};
   endfunction
   // Next pointer: only the low n bits move when a ring is set
   function automatic logic [31:0] nxt(input logic [31:0] a, input logic [1:0] s, input logic [3:0] n);
      logic [31:0] m;
      m = n == 0 ? 32'hffffffff : (32'h1 << n) - 32'h1;
      return (a & ~m) | ((a + (32'h1 << s)) & m);
   endfunction
   // Pacing level that the selected source shows: request line, timer or always
   function automatic logic pace_of(input logic [5:0] p);
      return p <= 6'h3a ? pdr[p] : p <= 6'h3e ? tmr[2'(p - 6'h3b)] : 1'b1;
   endfunction
   task wr(input logic [11:0] a, input logic [31:0] v);
      @(posedge aclk);
      awa <= a; wd <= v; awv <= 1; wv <= 1; br <= 1; i = 0;
      do begin
         @(posedge aclk);
         i++;
         if (awr) awv <= 0;
         if (wrd) wv <= 0;
      end while (bv !== 1'b1 && i < 50);
      rsp = bresp;
      br <= 0;
      if (i >= 50) begin mismatches++; results; end
   endtask
   task rd(input logic [11:0] a);
      @(posedge aclk);
      ara <= a; arv <= 1; rr <= 1; i = 0;
      do begin
         @(posedge aclk);
         i++;
         if (arr) arv <= 0;
      end while (rv !== 1'b1 && i < 50);
      d = rdata; rsp = rresp;
      rr <= 0;
      if (i >= 50) begin mismatches++; results; end
   endtask
   task idle;
      int k;
      for (k = 0; k < 60; k++) begin
         rd(`DCS_OFF_CTRL);
         if (d[24] === 1'b0) break;
      end
      if (k == 60) begin mismatches++; results; end
   endtask
   task start(input logic [31:0] cv, input logic [31:0] n);
      ra = $random(seed) & 32'hfff0; wa = $random(seed) & 32'hfff0; exp_wr = wa; exp_rd = ra;
      wr(`DCS_OFF_RADDR, ra); wr(`DCS_OFF_WADDR, wa); wr(`DCS_OFF_COUNT, n);
      i0 = irq_n; c0 = cf_n; s0 = sv_n;
      wr(`DCS_OFF_CTRL, cv);
   endtask
   // Memory-side monitor plus random pacing and wait lengths
   always @(posedge aclk) begin
      lat <= 2'($random(seed)); pdr <= 59'({$random(seed), $random(seed)}); tmr <= 4'($random(seed));
      irq_n += irq; cf_n += cf; sv_n += sv;
      // A read may only begin after the selected source requested at the edge before
      pq <= pace_of(ps); rq_d <= rdq;
      if (rdq && !rq_d) chk(32'(pq), 32'h1);
      if (rdq && rdn) begin
         last_rd <= rx.addr;
         chk(rx.addr, exp_rd);
         exp_rd = nxt(exp_rd, sz, rs ? 4'h0 : rn);
      end
      if (sv) chk(svd, rev({4{last_rd[7:0]}} ^ 32'h11223344, sz));
      if (wrq && wdn && !fwr) begin
         chk(wx.data, rev({4{last_rd[7:0]}} ^ 32'h11223344, bs ? sz : 2'h0));
         chk(wx.addr, exp_wr);
         exp_wr = nxt(exp_wr, sz, rs ? rn : 4'h0);
      end
   end
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1;
      rd(`DCS_OFF_CTRL); chk(d, 32'h00005000);
      rd(12'h3f0); chk(32'(rsp), 32'(`DCS_RESP_SLVERR)); chk(d, 32'h0);
      // Width, ring size and pacing source differ per pass; the checksum unit is off in the middle one
      for (int s = 0; s < 3; s++) begin
         sz = 2'(s); rn = 4'(s == 0 ? 0 : s + 2); rs = s != 1; ps = s == 0 ? 6'h3f : s == 1 ? 6'h05 : 6'h3c;
         sne <= s != 1; nx = 3 + ($random(seed) & 3);
         c = 32'h1ec00001 | (rs << 10) | (ps << 15) | (32'h3 << 11) | (rn << 6) | (s << 2);
         start(c, nx);
         rd(`DCS_OFF_CTRL); chk(d, (c & 32'h00ffffff) | 32'h01000000);
         idle; chk(irq_n - i0, 1); chk(cf_n - c0, 1); chk(ct, 4'h3);
         rd(`DCS_OFF_COUNT); chk(d, 32'h0); chk(sv_n - s0, s == 1 ? 32'h0 : nx);
      end
      // Long unreversed word sequence: pause it by clearing enable, then abort it
      sz = 2'h2; rn = 4'h0; bs = 0; ps = 6'h3f;
      start(32'h001fd009, 32'h40); wr(`DCS_OFF_CTRL, 32'h001fd008); rd(`DCS_OFF_CTRL); chk(d[24], 1);
      wr(`DCS_OFF_ABORT, 32'h400); rd(`DCS_OFF_CTRL); chk(d[24], 0);
      for (int k = 0; k < 2; k++) begin
         frd <= k == 0; fwr <= k == 1;
         start(32'h003fd009, 32'h4); idle; frd <= 0; fwr <= 0;
         chk(d[31:29], k ? 3'b101 : 3'b110); chk(irq_n - i0, 1); chk(cf_n - c0, 0);
         rd(k ? `DCS_OFF_WADDR : `DCS_OFF_RADDR); chk(d, k ? wa : ra);
         wr(`DCS_OFF_CTRL, (32'h1 << (30 - k)) | 32'h00205000); i0 = irq_n;
         wr(`DCS_OFF_CNT_TRIG, 0); rd(`DCS_OFF_CTRL); chk(d[31:29], 0); chk(irq_n - i0, 1);
      end
      results;
   end
endmodule

// ==== core/dcs_channel.sv ====
// One DMA channel: control and status register, pacing, chaining, ring wrap and transfer sequencing
// Function
// - bit 31 reads OR of both fault flags
// - bus error halts channel, always raises interrupt
// - bit 30 flags read fault, write-one clears
// - bit 29 flags write fault, write-one clears
// - busy rises at start, falls at end
// - enable cleared while busy pauses, busy held
// - abort register ends sequence and drops busy
// - bit 23 shows transfers to checksum unit
// - bit 22 reverses bytes per transfer width
// - quiet mode interrupts only on null trigger or bus error
// - pace codes 0 to 0x3a pick requests
// - codes 0x3b to 0x3e pick timers
// - code 0x3f means always requesting
// - completion triggers chain target unless self
// - chain target resets to 0xa, own number only at default CHANNEL
// - bit 10 picks read or write wrap
// - field 9:6 sets wrap region size
// - ring sizes span 2 to 32768 bytes
// - enable gates triggers and transfer issue
// - width code sets step of pointers
//
// The AXI4-Lite register port is this design's own decision.
`include "dcs_regs.svh"
module dcs_channel
   import dcs_pkg::*;
#(
   parameter logic [3:0] CHANNEL    = 4'ha,  // Own channel number
   parameter int         NUM_PERIPHERAL_DATA_REQUEST   = 59,    // Peripheral request lines
   parameter int         NUM_TIMERS = 4      // Pacing timers fitted, two of them optional
) (
   // Clock and reset
   input  wire logic                aclk,
   input  wire logic                aresetn,
   // AXI4-Lite write channels
   input  wire logic [11:0]         s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   // AXI4-Lite read channels
   input  wire logic [11:0]         s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   // Pacing sources, same clock
   input  wire logic [NUM_PERIPHERAL_DATA_REQUEST-1:0] peripheral_data_request,
   input  wire logic [3:0]          pace_timer,
   // Chain trigger from other channels
   input  wire logic                chain_trigger_in,
   // Memory side read port
   output logic                     rd_req,
   output dcs_xfer_s                rd_xfer,
   input  wire logic                rd_done,
   input  wire logic                rd_error,
   input  wire logic [31:0]         rd_data,
   // Memory side write port
   output logic                     wr_req,
   output dcs_xfer_s                wr_xfer,
   input  wire logic                wr_done,
   input  wire logic                wr_error,
   // Checksum unit
   input  wire logic                sniff_unit_enable,
   input  wire logic [3:0]          sniff_unit_channel,
   output logic                     sniff_valid,
   output logic [31:0]              sniff_data,
   // Events toward the shared interrupt and chaining logic
   output logic                     channel_irq,
   output logic                     chain_fire,
   output logic [3:0]               chain_target
);

   dcs_state_s st;           // Registered state
   dcs_state_s next_st;      // Next state
   logic       transfer_pace_request; // Selected pacing level
   logic       wr_fire;      // Write address and data both held
   logic       ar_fire;      // Read address taken
   logic       ctrl_hit;     // Write lands on the control word
   logic       abort_hit;    // Abort names this channel
   logic       trig_hit;     // Count-and-trigger write
   logic [31:0] wmerged;     // Write data merged under strobes
   logic        start;       // Sequence begins this cycle

   // Step of a pointer for a width code
   function automatic logic [31:0] step_of(input logic [1:0] sz);
      step_of = (sz == 2'h0) ? 32'h1 : (sz == 2'h1) ? 32'h2 : 32'h4;
   endfunction

   // Advance a pointer, keeping bits above the ring untouched when wrapping
   function automatic logic [31:0] advance(input logic [31:0] a, input logic [1:0] sz,
                                           input logic [3:0] n, input logic wrap);
      logic [31:0] mask;
      logic [31:0] sum;
      mask = (32'h1 << n) - 32'h1;
      sum  = a + step_of(sz);
      if (wrap && (n != 4'h0)) begin
         advance = (a & ~mask) | (sum & mask);
      end else begin
         advance = sum;
      end
   endfunction

   // Byte reversal by transfer width
   function automatic logic [31:0] reverse(input logic [31:0] d, input logic [1:0] sz);
      if (sz == 2'h1) begin
         reverse = {d[23:16], d[31:24], d[7:0], d[15:8]};
      end else if (sz == 2'h2) begin
         reverse = {d[7:0], d[15:8], d[23:16], d[31:24]};
      end else begin
         reverse = d;                                     // bytes pass unchanged
      end
   endfunction

   // Control word as software reads it
   function automatic logic [31:0] ctrl_word(input dcs_state_s s);
      ctrl_word = 32'h0;                                  // reserved bits stay zero
      ctrl_word[`DCS_BIT_BUS_ERR] = s.rd_err | s.wr_err;
      ctrl_word[`DCS_BIT_RD_ERR]  = s.rd_err;
      ctrl_word[`DCS_BIT_WR_ERR]  = s.wr_err;
      ctrl_word[`DCS_BIT_BUSY]    = s.busy;
      ctrl_word[`DCS_BIT_SNIFF]   = s.sniff_en;
      ctrl_word[`DCS_BIT_REVERSE] = s.reverse;
      ctrl_word[`DCS_BIT_QUIET]   = s.quiet;
      ctrl_word[`DCS_PACE_HI:`DCS_PACE_LO]   = s.pace_sel;
      ctrl_word[`DCS_CHAIN_HI:`DCS_CHAIN_LO] = s.chain;
      ctrl_word[`DCS_BIT_RING_SEL]           = s.ring_sel;
      ctrl_word[`DCS_RING_HI:`DCS_RING_LO]   = s.ring_size;
      ctrl_word[`DCS_SIZE_HI:`DCS_SIZE_LO]   = s.size;
      ctrl_word[`DCS_BIT_EN]      = s.en;
   endfunction

   // Pacing selection; optional timers that are not fitted never request
   always_comb begin
      if (st.pace_sel <= `DCS_PACE_LINE_MAX) begin
         transfer_pace_request = (int'(st.pace_sel) < NUM_PERIPHERAL_DATA_REQUEST) ?
                                 peripheral_data_request[st.pace_sel] : 1'b0;
      end else if (st.pace_sel <= `DCS_PACE_TMR_MAX) begin
         transfer_pace_request = (int'(st.pace_sel - `DCS_PACE_TMR0) < NUM_TIMERS) ?
                                 pace_timer[2'(st.pace_sel - `DCS_PACE_TMR0)] : 1'b0;
      end else begin
         transfer_pace_request = 1'b1;
      end
   end

   // Bus handshakes: one write and one read at a time
   assign s_axi_awready = !st.aw_got && !st.bvalid;
   assign s_axi_wready  = !st.w_got && !st.bvalid;
   assign s_axi_arready = !st.rvalid;
   assign wr_fire  = st.aw_got && st.w_got && !st.bvalid;
   assign ar_fire  = s_axi_arvalid && s_axi_arready;
   assign wmerged  = {st.w_strb[3] ? st.w_data[31:24] : 8'h0, st.w_strb[2] ? st.w_data[23:16] : 8'h0,
                      st.w_strb[1] ? st.w_data[15:8] : 8'h0, st.w_strb[0] ? st.w_data[7:0] : 8'h0};
   assign ctrl_hit  = wr_fire && (st.aw_addr == `DCS_OFF_CTRL);
   assign trig_hit  = wr_fire && (st.aw_addr == `DCS_OFF_CNT_TRIG);
   assign abort_hit = wr_fire && (st.aw_addr == `DCS_OFF_ABORT) && wmerged[CHANNEL];

   // Next state: register file, bus slave and transfer sequencer
   always_comb begin
      next_st = st;
      next_st.irq         = 1'b0;
      next_st.chain_fire  = 1'b0;
      next_st.sniff_valid = 1'b0;
      start = 1'b0;
      // Collect write address and data in either order
      if (s_axi_awvalid && s_axi_awready) begin
         next_st.aw_got  = 1'b1;
         next_st.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_st.w_got  = 1'b1;
         next_st.w_data = s_axi_wdata;
         next_st.w_strb = s_axi_wstrb;
      end
      if (st.bvalid && s_axi_bready) begin
         next_st.bvalid = 1'b0;
      end
      // Register writes, decoded by address
      if (wr_fire) begin
         next_st.aw_got = 1'b0;
         next_st.w_got  = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp  = `DCS_RESP_OKAY;
         if (st.aw_addr == `DCS_OFF_CTRL) begin
            // Fault flags clear on one; a new fault below wins
            if (wmerged[`DCS_BIT_RD_ERR]) next_st.rd_err = 1'b0;
            if (wmerged[`DCS_BIT_WR_ERR]) next_st.wr_err = 1'b0;
            if (st.w_strb[2]) begin
               next_st.sniff_en = st.w_data[`DCS_BIT_SNIFF];
               next_st.reverse  = st.w_data[`DCS_BIT_REVERSE];
               next_st.quiet    = st.w_data[`DCS_BIT_QUIET];
               next_st.pace_sel[5:1] = st.w_data[`DCS_PACE_HI:16];
            end
            if (st.w_strb[1]) begin
               next_st.pace_sel[0] = st.w_data[`DCS_PACE_LO];
               next_st.chain       = st.w_data[`DCS_CHAIN_HI:`DCS_CHAIN_LO];
               next_st.ring_sel    = st.w_data[`DCS_BIT_RING_SEL];
               next_st.ring_size[3:2] = st.w_data[`DCS_RING_HI:8];
            end
            if (st.w_strb[0]) begin
               next_st.ring_size[1:0] = st.w_data[7:`DCS_RING_LO];
               next_st.size = st.w_data[`DCS_SIZE_HI:`DCS_SIZE_LO];
               next_st.en   = st.w_data[`DCS_BIT_EN];
            end
         end else if (st.aw_addr == `DCS_OFF_RADDR) begin
            if (!st.busy) next_st.rd_addr = wmerged;
         end else if (st.aw_addr == `DCS_OFF_WADDR) begin
            if (!st.busy) next_st.wr_addr = wmerged;
         end else if (st.aw_addr == `DCS_OFF_COUNT || st.aw_addr == `DCS_OFF_CNT_TRIG) begin
            if (!st.busy) next_st.count = wmerged;
            // A null trigger closes a chain and speaks only in quiet mode
            if (trig_hit && wmerged == 32'h0 && st.quiet) next_st.irq = 1'b1;
         end else if (st.aw_addr == `DCS_OFF_ABORT) begin
            next_st.bresp = `DCS_RESP_OKAY;
         end else begin
            next_st.bresp = `DCS_RESP_SLVERR;
         end
      end
      // Control write or count trigger starts an idle enabled channel
      if ((ctrl_hit || (trig_hit && wmerged != 32'h0) || chain_trigger_in) && next_st.en && !st.busy &&
          next_st.count != 32'h0 && !abort_hit) begin
         start = 1'b1;
         next_st.busy  = 1'b1;
         next_st.state = ST_PACE;
      end
      // Transfer sequencer
      case (st.state)
         ST_PACE: begin
            // Paused while disabled, busy held
            if (st.en && transfer_pace_request) begin
               next_st.state = ST_READ;
            end
         end
         ST_READ: begin
            if (rd_done && rd_error) begin
               // Pointer stays on the failing access
               next_st.rd_err = 1'b1;
               next_st.busy   = 1'b0;
               next_st.irq    = 1'b1;
               next_st.state  = ST_IDLE;
            end else if (rd_done) begin
               next_st.data    = st.reverse ? reverse(rd_data, st.size) : rd_data;
               next_st.rd_addr = advance(st.rd_addr, st.size, st.ring_size, !st.ring_sel);
               next_st.state   = ST_WRITE;
            end
         end
         ST_WRITE: begin
            if (wr_done && wr_error) begin
               next_st.wr_err = 1'b1;
               next_st.busy   = 1'b0;
               next_st.irq    = 1'b1;
               next_st.state  = ST_IDLE;
            end else if (wr_done) begin
               next_st.wr_addr = advance(st.wr_addr, st.size, st.ring_size, st.ring_sel);
               next_st.count   = st.count - 32'h1;
               next_st.sniff_valid = st.sniff_en && sniff_unit_enable &&
                                     (sniff_unit_channel == CHANNEL);
               if (st.count == 32'h1) begin
                  next_st.busy       = 1'b0;
                  next_st.irq        = !st.quiet;
                  next_st.chain_fire = (st.chain != CHANNEL);
                  next_st.state      = ST_IDLE;
               end else begin
                  next_st.state = ST_PACE;
               end
            end
         end
         default: begin
            // Idle: keep a start decided above, otherwise stay put
            next_st.state = start ? ST_PACE : ST_IDLE;
         end
      endcase
      // Abort ends the sequence; a memory access in flight is simply dropped
      if (abort_hit) begin
         next_st.busy  = 1'b0;
         next_st.state = ST_IDLE;
      end
      // Read path: one-cycle answer
      if (st.rvalid && s_axi_rready) begin
         next_st.rvalid = 1'b0;
      end
      if (ar_fire) begin
         next_st.rvalid = 1'b1;
         next_st.rresp  = `DCS_RESP_OKAY;
         if (s_axi_araddr == `DCS_OFF_CTRL) begin
            next_st.rdata = ctrl_word(st);
         end else if (s_axi_araddr == `DCS_OFF_RADDR) begin
            next_st.rdata = st.rd_addr;
         end else if (s_axi_araddr == `DCS_OFF_WADDR) begin
            next_st.rdata = st.wr_addr;
         end else if (s_axi_araddr == `DCS_OFF_COUNT || s_axi_araddr == `DCS_OFF_CNT_TRIG) begin
            next_st.rdata = st.count;
         end else if (s_axi_araddr == `DCS_OFF_ABORT) begin
            next_st.rdata = 32'h0;
         end else begin
            next_st.rdata = 32'h0;
            next_st.rresp = `DCS_RESP_SLVERR;
         end
      end
   end

   // State register; reset leaves the channel idle with chain target 0xa, unchained at default CHANNEL
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st       <= '0;
         st.state <= ST_IDLE;
         st.chain <= `DCS_RST_CHAIN;
      end else begin
         st <= next_st;
      end
   end

   // Outputs
   assign s_axi_bvalid = st.bvalid;
   assign s_axi_bresp  = st.bresp;
   assign s_axi_rvalid = st.rvalid;
   assign s_axi_rdata  = st.rdata;
   assign s_axi_rresp  = st.rresp;
   assign rd_req       = (st.state == ST_READ);
   assign rd_xfer      = '{addr: st.rd_addr, data: 32'h0, size: st.size};
   assign wr_req       = (st.state == ST_WRITE);
   assign wr_xfer      = '{addr: st.wr_addr, data: st.data, size: st.size};
   assign sniff_valid  = st.sniff_valid;
   assign sniff_data   = st.data;
   assign channel_irq  = st.irq;
   assign chain_fire   = st.chain_fire;
   assign chain_target = st.chain;

   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence read_fault_s;
      rd_req && rd_done && rd_error && !abort_hit;
   endsequence
   sequence write_fault_s;
      wr_req && wr_done && wr_error && !abort_hit;
   endsequence

   bus_err_or_a: assert property (ar_fire && s_axi_araddr == `DCS_OFF_CTRL |=>
      s_axi_rdata[31] == ($past(st.rd_err) | $past(st.wr_err)))
      else $error("bus error bit differs from fault flags");
   read_fault_a: assert property (read_fault_s |=> st.rd_err && !st.busy && channel_irq
      && rd_xfer.addr == $past(rd_xfer.addr)) else $error("read fault not recorded");
   write_fault_a: assert property (write_fault_s |=> st.wr_err && !st.busy && channel_irq
      && wr_xfer.addr == $past(wr_xfer.addr)) else $error("write fault not recorded");
   pause_hold_a: assert property (st.busy && !st.en && st.state == ST_PACE && !abort_hit
      |=> st.busy && st.state == ST_PACE) else $error("paused channel lost busy");
   abort_drop_a: assert property (abort_hit |=> !st.busy && !rd_req && !wr_req)
      else $error("abort did not end sequence");
   quiet_end_a: assert property (wr_req && wr_done && !wr_error && st.count == 32'h1 && !abort_hit
      |=> channel_irq == !$past(st.quiet) && !st.busy) else $error("end of block interrupt wrong");
   chain_fire_a: assert property (chain_fire |-> chain_target != CHANNEL && $past(wr_done))
      else $error("chain fired to itself");
   unpaced_go_a: assert property (st.state == ST_PACE && st.en && st.pace_sel == 6'h3f && !abort_hit
      |=> rd_req) else $error("unpaced channel did not read");
   rsvd_zero_a: assert property (ar_fire && s_axi_araddr == `DCS_OFF_CTRL |=>
      s_axi_rdata[28:25] == 4'h0) else $error("reserved bits not zero");
   ring_keep_a: assert property (rd_req && rd_done && !rd_error && !st.ring_sel && st.ring_size != 4'h0
      |=> ((rd_xfer.addr ^ $past(rd_xfer.addr)) >> $past(st.ring_size)) == 32'h0)
      else $error("read ring wrap changed upper bits");
   busy_start_a: assert property ($rose(st.busy) |-> $past(st.en) || $past(next_st.en))
      else $error("busy rose without enable");

endmodule

// ==== shared/dcs_pkg.sv ====
// Types shared by the channel control block
package dcs_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_PACE, ST_READ, ST_WRITE} dcs_state_e;
   // One bus transfer as presented to the memory side
   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] data;
      logic [1:0]  size;
   } dcs_xfer_s;
   // Whole state of the channel
   typedef struct packed {
      dcs_state_e  state;
      logic        en;
      logic [1:0]  size;
      logic [3:0]  ring_size;
      logic        ring_sel;
      logic [3:0]  chain;
      logic [5:0]  pace_sel;
      logic        quiet;
      logic        reverse;
      logic        sniff_en;
      logic        busy;
      logic        rd_err;
      logic        wr_err;
      logic [31:0] rd_addr;
      logic [31:0] wr_addr;
      logic [31:0] count;
      logic [31:0] data;
      logic        irq;
      logic        chain_fire;
      logic        sniff_valid;
      logic        aw_got;
      logic        w_got;
      logic [11:0] aw_addr;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } dcs_state_s;
endpackage

// ==== shared/dcs_regs.svh ====
// Register offsets, field positions and reset values of the channel control block
`ifndef DCS_REGS_SVH
`define DCS_REGS_SVH
`define DCS_OFF_RADDR     12'h280
`define DCS_OFF_WADDR     12'h284
`define DCS_OFF_COUNT     12'h288
`define DCS_OFF_CTRL      12'h28c
`define DCS_OFF_CNT_TRIG  12'h29c
`define DCS_OFF_ABORT     12'h2a0
`define DCS_BIT_BUS_ERR   31
`define DCS_BIT_RD_ERR    30
`define DCS_BIT_WR_ERR    29
`define DCS_BIT_BUSY      24
`define DCS_BIT_SNIFF     23
`define DCS_BIT_REVERSE   22
`define DCS_BIT_QUIET     21
`define DCS_PACE_HI       20
`define DCS_PACE_LO       15
`define DCS_CHAIN_HI      14
`define DCS_CHAIN_LO      11
`define DCS_BIT_RING_SEL  10
`define DCS_RING_HI       9
`define DCS_RING_LO       6
`define DCS_SIZE_HI       3
`define DCS_SIZE_LO       2
`define DCS_BIT_EN        0
`define DCS_RST_CHAIN     4'ha
`define DCS_PACE_LINE_MAX 6'h3a
`define DCS_PACE_TMR0     6'h3b
`define DCS_PACE_TMR_MAX  6'h3e
`define DCS_RESP_OKAY     2'h0
`define DCS_RESP_SLVERR   2'h2
`endif
